// ==== rtl/dcb_pkg.sv ====
/*
 * Shared constants of the command decoder and bank state machine.
 * Assumes one 250 MHz clock; register offsets are AXI4-Lite byte addresses.
 */
`default_nettype none
package dcb_pkg;
  // ****************************************
  // Register map and reset values
  // ****************************************
  localparam logic [7:0] OFF_TIMING = 8'h00;
  localparam logic [7:0] OFF_BURST  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MODE   = 8'h0C;
  localparam logic [7:0] OFF_REFCNT = 8'h10;
  localparam logic [31:0] TIMING_RST = 32'h02_08_03_03;
  localparam logic [4:0]  BURST_RST  = 5'h04;
  localparam int ACTIVATE_TO_ACCESS_DELAY_LSB = 0;
  localparam int TRP_LSB  = 8;
  localparam int REFRESH_CYCLE_TIME_LSB = 16;
  localparam int MODE_REGISTER_DELAY_LSB = 24;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int AP_BIT = 10;
  // ****************************************
  // States and commands
  // ****************************************
  typedef enum logic [5:0] {
    BK_IDLE = 6'h01, BK_ACTING = 6'h02, BK_ACTIVE = 6'h04,
    BK_READ = 6'h08, BK_WRITE = 6'h10, BK_PRE = 6'h20
  } dcb_bank_t;
  typedef enum logic [4:0] {
    DV_NORM = 5'h01, DV_REF = 5'h02, DV_MRS = 5'h04,
    DV_SREF = 5'h08, DV_DPD = 5'h10
  } dcb_dev_t;
  typedef enum logic [2:0] {
    C_NOP = 3'h0, C_ACT = 3'h1, C_RD = 3'h2, C_WR = 3'h3,
    C_PRE = 3'h4, C_BST = 3'h5, C_REF = 3'h6, C_LMR = 3'h7
  } dcb_cmd_t;
endpackage
`default_nettype wire

// ==== rtl/dcb_top.sv ====
/*
 * Command decoder, per-bank state machine and small data array of a
 * four-bank low-power DDR memory, with an AXI4-Lite register slave.
 * Assumes commands and data are synchronous to aclk, one data word per cycle.
 */
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
// How it works
// (R1) Chip select high decodes as no command; running work continues.
// (R2) No-operation starts nothing and disturbs nothing.
// (R3) Controller loads mode only with all banks idle, then waits.
// (R4) Activate opens the addressed row until that bank is precharged.
// (R5) Read bursts from an open row; bit ten asks auto precharge.
// (R6) Write bursts to an open row; bit ten asks auto precharge.
// (R7) Bytes with mask low are stored, masked bytes are left alone.
// (R8) Controller finishes every burst before stopping the clock.
// (R9) Precharge with bit ten closes all banks, else the chosen one.
// (R10) Controller activates a precharged bank before reading or writing.
// (R11) Burst terminate ends the latest non-auto-precharge read, row stays open.
// (R12) Auto refresh uses the internal row counter, ignores address.
// (R13) Refresh with clock enable low enters self refresh.
// (R14) Controller should refresh in bursts around self refresh.
// (R15) Burst terminate with clock enable low enters deep power-down.
// (R16) Idle bank takes activate, refresh and mode load.
// (R17) Active bank takes read, write and precharge.
// (R18) Read burst takes read, write, terminate; precharge cuts it.
// (R19) Write burst takes read or write; precharge cuts it.
// (R20) Table holds only with clock enable high on two edges.
// (R21) Controller sends nothing to an activating or precharging bank.
// (R22) Banks go active after the activate delay, idle after precharge time.
// (R23) Inputs are sampled on every rising clock edge.
// (R24) Controller ends a read before a write, or terminates it.
// (R25) Refresh and mode load only with all banks idle, no burst.
// (R26) Controller masks write bytes cut by a read or precharge.
// (R27) Per-bank timers use counts held in a software register.
`timescale 1ns/1ns
`default_nettype none
module dcb_top #(
  parameter int ROW_IDX_BITS = 2,
  parameter int COL_IDX_BITS = 4,
  parameter int ADDR_BITS    = 13
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output var  logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output var  logic                 s_axi_wready,
  output var  logic [1:0]           s_axi_bresp,
  output var  logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output var  logic                 s_axi_arready,
  output var  logic [31:0]          s_axi_rdata,
  output var  logic [1:0]           s_axi_rresp,
  output var  logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 cke,
  input  wire logic                 cs_n,
  input  wire logic                 ras_n,
  input  wire logic                 cas_n,
  input  wire logic                 we_n,
  input  wire logic                 bank_sel_bit0,
  input  wire logic                 bank_sel_bit1,
  input  wire logic [ADDR_BITS-1:0] addr,
  input  wire logic [15:0]          wdata,
  input  wire logic [1:0]           write_byte_mask,
  output var  logic [15:0]          rdata,
  output var  logic                 rdata_valid
);
  localparam int MEM_WORDS = 4 << (ROW_IDX_BITS + COL_IDX_BITS);
  localparam int MEM_AW = 2 + ROW_IDX_BITS + COL_IDX_BITS;

  // Decodes the four command pins; chip select high is a plain no-op.
  function automatic dcb_pkg::dcb_cmd_t decode(input logic cs, r, c, w);
    if (cs) return dcb_pkg::C_NOP; // [R1]
    return dcb_pkg::dcb_cmd_t'({~r, ~c, ~w} == 3'h0 ? 3'h0 :
      ~r & c & w ? 3'h1 : r & ~c & w ? 3'h2 : r & ~c & ~w ? 3'h3 :
      ~r & c & ~w ? 3'h4 : r & c & ~w ? 3'h5 : ~r & ~c & w ? 3'h6 : 3'h7);
  endfunction

  // Loads a timer, never below one cycle.
  function automatic logic [7:0] clamp(input logic [7:0] v);
    return (v == 8'h00) ? 8'h01 : v;
  endfunction

  // Forms the array word address from bank, row and column.
  function automatic logic [MEM_AW-1:0] midx(input logic [1:0] b,
      input logic [ADDR_BITS-1:0] r, input logic [COL_IDX_BITS-1:0] c);
    return {b, r[ROW_IDX_BITS-1:0], c};
  endfunction

  // ****************************************
  // State
  // ****************************************
  dcb_pkg::dcb_bank_t         bank_st_r [4];
  logic [7:0]                 bank_cnt_r [4];
  logic [ADDR_BITS-1:0]       row_r [4];
  dcb_pkg::dcb_dev_t          dev_r;
  logic [7:0]                 dev_cnt_r;
  logic                       cke_prev_r;
  logic                       burst_live_r, burst_rd_r, burst_ap_r;
  logic [1:0]                 burst_bank_r;
  logic [4:0]                 burst_cnt_r;
  logic [COL_IDX_BITS-1:0]    col_r;
  logic [15:0]                mem [MEM_WORDS];
  logic [31:0]                timing_r;
  logic [4:0]                 burst_len_r;
  logic [ADDR_BITS+1:0]       mode_r;
  logic [15:0]                refresh_row_r;
  logic                       data_lost_r;
  logic [7:0]                 illegal_cnt_r;
  logic [7:0]                 aw_addr_r, ar_addr_nxt;
  logic [31:0]                w_data_r;
  logic [3:0]                 w_strb_r;

  // ****************************************
  // Command acceptance
  // ****************************************
  dcb_pkg::dcb_cmd_t cmd;
  logic [1:0] ba;
  logic       sel, all_idle, a10, act_ok, rd_ok, wr_ok, pre_ok, bst_ok;
  logic       ref_ok, lmr_ok, sref_ok, dpd_ok, illegal;
  logic [7:0] t_rcd, t_rp, t_rfc, t_mrd;

  // Commands count only with clock enable high on the last edge, and on this one too except for self refresh and deep power-down entry.
  always_comb begin
    cmd = decode(cs_n, ras_n, cas_n, we_n); // [R23]
    ba = {bank_sel_bit1, bank_sel_bit0};
    a10 = addr[dcb_pkg::AP_BIT];
    sel = cke_prev_r && cke && dev_r == dcb_pkg::DV_NORM; // [R20]
    all_idle = !burst_live_r;
    for (int i = 0; i < 4; i++) begin
      all_idle &= bank_st_r[i] == dcb_pkg::BK_IDLE;
    end
    act_ok = sel && cmd == dcb_pkg::C_ACT && bank_st_r[ba] == dcb_pkg::BK_IDLE; // [R16]
    rd_ok = sel && cmd == dcb_pkg::C_RD && (bank_st_r[ba] inside
      {dcb_pkg::BK_ACTIVE, dcb_pkg::BK_READ, dcb_pkg::BK_WRITE}); // [R17] [R18] [R19]
    wr_ok = sel && cmd == dcb_pkg::C_WR && (bank_st_r[ba] inside
      {dcb_pkg::BK_ACTIVE, dcb_pkg::BK_READ, dcb_pkg::BK_WRITE}); // [R17] [R18] [R19]
    pre_ok = sel && cmd == dcb_pkg::C_PRE && (a10 || !(bank_st_r[ba] inside
      {dcb_pkg::BK_ACTING, dcb_pkg::BK_PRE}));
    bst_ok = sel && cmd == dcb_pkg::C_BST && burst_live_r && burst_rd_r && !burst_ap_r; // [R11]
    ref_ok = sel && cmd == dcb_pkg::C_REF && all_idle; // [R16]
    lmr_ok = sel && cmd == dcb_pkg::C_LMR && all_idle; // [R16]
    sref_ok = cke_prev_r && !cke && dev_r == dcb_pkg::DV_NORM && !cs_n &&
      cmd == dcb_pkg::C_REF && all_idle; // [R13]
    dpd_ok = cke_prev_r && !cke && dev_r == dcb_pkg::DV_NORM && !cs_n &&
      cmd == dcb_pkg::C_BST; // [R15]
    illegal = sel && cmd != dcb_pkg::C_NOP && !(act_ok || rd_ok || wr_ok ||
      pre_ok || bst_ok || ref_ok || lmr_ok); // [R2]
    t_rcd = clamp(timing_r[dcb_pkg::ACTIVATE_TO_ACCESS_DELAY_LSB +: 8]); // [R27]
    t_rp  = clamp(timing_r[dcb_pkg::TRP_LSB +: 8]);
    t_rfc = clamp(timing_r[dcb_pkg::REFRESH_CYCLE_TIME_LSB +: 8]);
    t_mrd = clamp(timing_r[dcb_pkg::MODE_REGISTER_DELAY_LSB +: 8]);
  end

  logic burst_stop;
  assign burst_stop = burst_live_r && (burst_cnt_r == 5'h01 || bst_ok ||
    ((rd_ok || wr_ok) && ba != burst_bank_r));

  // ****************************************
  // Per-bank state machines
  // ****************************************
  // Command effects win over burst ends, which win over timer expiry.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int b = 0; b < 4; b++) begin
        bank_st_r[b] <= dcb_pkg::BK_IDLE;
        bank_cnt_r[b] <= 8'h00;
        row_r[b] <= '0;
      end
    end else begin
      for (int b = 0; b < 4; b++) begin
        if (act_ok && ba == 2'(b)) begin
          bank_st_r[b] <= dcb_pkg::BK_ACTING; // [R4]
          bank_cnt_r[b] <= t_rcd;
          row_r[b] <= addr;
        end else if (pre_ok && (a10 || ba == 2'(b)) && (bank_st_r[b] inside
            {dcb_pkg::BK_ACTIVE, dcb_pkg::BK_READ, dcb_pkg::BK_WRITE})) begin
          bank_st_r[b] <= dcb_pkg::BK_PRE; // [R9] [R18] [R19]
          bank_cnt_r[b] <= t_rp;
        end else if ((rd_ok || wr_ok) && ba == 2'(b)) begin
          bank_st_r[b] <= rd_ok ? dcb_pkg::BK_READ : dcb_pkg::BK_WRITE; // [R5] [R6]
        end else if (burst_stop && burst_bank_r == 2'(b)) begin
          if (burst_ap_r && !bst_ok) begin
            bank_st_r[b] <= dcb_pkg::BK_PRE; // [R5] [R6]
            bank_cnt_r[b] <= t_rp;
          end else begin
            bank_st_r[b] <= dcb_pkg::BK_ACTIVE; // [R11]
          end
        end else if (bank_st_r[b] inside {dcb_pkg::BK_ACTING, dcb_pkg::BK_PRE}) begin
          if (bank_cnt_r[b] == 8'h01) begin
            bank_st_r[b] <= bank_st_r[b] == dcb_pkg::BK_ACTING ?
              dcb_pkg::BK_ACTIVE : dcb_pkg::BK_IDLE; // [R22]
          end
          bank_cnt_r[b] <= bank_cnt_r[b] - 8'h01;
        end
      end
    end
  end

  // ****************************************
  // Burst engine and data array
  // ****************************************
  // Tracks the one burst under way; a precharge to its bank cuts it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burst_live_r <= 1'b0;
      burst_rd_r <= 1'b0;
      burst_ap_r <= 1'b0;
      burst_bank_r <= 2'h0;
      burst_cnt_r <= 5'h00;
      col_r <= '0;
    end else if (rd_ok || wr_ok) begin
      burst_live_r <= 1'b1;
      burst_rd_r <= rd_ok;
      burst_ap_r <= a10; // [R5] [R6]
      burst_bank_r <= ba;
      burst_cnt_r <= (burst_len_r == 5'h00) ? 5'h01 : burst_len_r;
      col_r <= addr[COL_IDX_BITS-1:0];
    end else if (burst_stop || (pre_ok && (a10 || ba == burst_bank_r))) begin
      burst_live_r <= 1'b0; // [R11] [R18] [R19]
    end else if (burst_live_r) begin
      burst_cnt_r <= burst_cnt_r - 5'h01;
      col_r <= col_r + COL_IDX_BITS'(1);
    end
  end

  // Stores unmasked bytes of each write beat and returns read beats.
  always_ff @(posedge aclk) begin
    if (burst_live_r && !burst_rd_r) begin
      for (int k = 0; k < 2; k++) begin
        if (!write_byte_mask[k]) begin
          mem[midx(burst_bank_r, row_r[burst_bank_r], col_r)][8*k +: 8] <= wdata[8*k +: 8]; // [R7]
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= 16'h0000;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= burst_live_r && burst_rd_r;
      rdata <= mem[midx(burst_bank_r, row_r[burst_bank_r], col_r)];
    end
  end

  // ****************************************
  // Device-wide modes
  // ****************************************
  // Refresh, mode load, self refresh and deep power-down.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_r <= dcb_pkg::DV_NORM;
      dev_cnt_r <= 8'h00;
      cke_prev_r <= 1'b0;
      mode_r <= '0;
      refresh_row_r <= 16'h0000;
      data_lost_r <= 1'b0;
      illegal_cnt_r <= 8'h00;
    end else begin
      cke_prev_r <= cke;
      if (illegal && illegal_cnt_r != 8'hFF) begin
        illegal_cnt_r <= illegal_cnt_r + 8'h01;
      end
      unique case (dev_r)
        dcb_pkg::DV_NORM: begin
          if (ref_ok || sref_ok) begin
            refresh_row_r <= refresh_row_r + 16'h0001; // [R12]
            dev_r <= ref_ok ? dcb_pkg::DV_REF : dcb_pkg::DV_SREF; // [R13]
            dev_cnt_r <= t_rfc;
          end else if (lmr_ok) begin
            mode_r <= {ba, addr};
            dev_r <= dcb_pkg::DV_MRS;
            dev_cnt_r <= t_mrd;
          end else if (dpd_ok) begin
            dev_r <= dcb_pkg::DV_DPD; // [R15]
            data_lost_r <= 1'b1;
          end
        end
        dcb_pkg::DV_REF, dcb_pkg::DV_MRS: begin
          if (dev_cnt_r == 8'h01) begin
            dev_r <= dcb_pkg::DV_NORM;
          end
          dev_cnt_r <= dev_cnt_r - 8'h01;
        end
        dcb_pkg::DV_SREF, dcb_pkg::DV_DPD: begin
          if (cke) begin
            dev_r <= dcb_pkg::DV_NORM; // [R13]
          end
        end
      endcase
    end
  end

  // ****************************************
  // AXI4-Lite slave
  // ****************************************
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;

  // Read decode of the register map.
  always_comb begin
    rd_resp = dcb_pkg::RESP_OKAY;
    ar_addr_nxt = s_axi_araddr;
    rd_word = 32'h0000_0000;
    unique case (ar_addr_nxt)
      dcb_pkg::OFF_TIMING: rd_word = timing_r;
      dcb_pkg::OFF_BURST:  rd_word = {27'h0, burst_len_r};
      dcb_pkg::OFF_STATUS: rd_word = {illegal_cnt_r[1:0], data_lost_r, dev_r,
        bank_st_r[3], bank_st_r[2], bank_st_r[1], bank_st_r[0]};
      dcb_pkg::OFF_MODE:   rd_word = {{(30-ADDR_BITS){1'b0}}, mode_r};
      dcb_pkg::OFF_REFCNT: rd_word = {illegal_cnt_r, 8'h00, refresh_row_r};
      default:             rd_resp = dcb_pkg::RESP_SLVERR;
    endcase
  end

  // Write channel: address and data taken in either order, then answered.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= dcb_pkg::RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      timing_r <= dcb_pkg::TIMING_RST;
      burst_len_r <= dcb_pkg::BURST_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= dcb_pkg::RESP_OKAY;
        if (aw_addr_r == dcb_pkg::OFF_TIMING) begin
          for (int k = 0; k < 4; k++) begin
            if (w_strb_r[k]) timing_r[8*k +: 8] <= w_data_r[8*k +: 8]; // [R27]
          end
        end else if (aw_addr_r == dcb_pkg::OFF_BURST) begin
          if (w_strb_r[0]) burst_len_r <= w_data_r[4:0];
        end else if (!(aw_addr_r inside {dcb_pkg::OFF_STATUS, dcb_pkg::OFF_MODE,
            dcb_pkg::OFF_REFCNT})) begin
          s_axi_bresp <= dcb_pkg::RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= dcb_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_deselect_quiet: assert property (cs_n && cke && bank_st_r[0] == dcb_pkg::BK_IDLE |=> // [R1]
    bank_st_r[0] == dcb_pkg::BK_IDLE) else $error("Deselect changed an idle bank.");
  a_nop_quiet: assert property (cmd == dcb_pkg::C_NOP |=> $stable(mode_r) && $stable(refresh_row_r)) // [R2]
    else $error("No-op was taken as a command.");
  a_act_opens_row: assert property (act_ok && ba == 2'h0 |=> bank_st_r[0] == dcb_pkg::BK_ACTING // [R4]
    && row_r[0] == $past(addr) && bank_cnt_r[0] == $past(t_rcd)) else $error("Activate failed.");
  a_ap_read_closes: assert property (burst_live_r && burst_ap_r && burst_cnt_r == 5'h01 // [R5]
    && cmd == dcb_pkg::C_NOP |=> bank_st_r[$past(burst_bank_r)] == dcb_pkg::BK_PRE)
    else $error("Auto precharge did not start.");
  a_mask_write: assert property (burst_live_r && !burst_rd_r && !write_byte_mask[0] |=> // [R7]
    mem[$past(midx(burst_bank_r, row_r[burst_bank_r], col_r))][7:0] == $past(wdata[7:0]))
    else $error("Unmasked byte not stored.");
  a_pre_all: assert property (pre_ok && a10 && bank_st_r[1] == dcb_pkg::BK_ACTIVE |=> // [R9]
    bank_st_r[1] == dcb_pkg::BK_PRE) else $error("Precharge all missed a bank.");
  a_bst_keeps_row: assert property (bst_ok |=> !burst_live_r && // [R11]
    bank_st_r[$past(burst_bank_r)] == dcb_pkg::BK_ACTIVE) else $error("Terminate closed the row.");
  a_ref_counter: assert property (ref_ok |=> dev_r == dcb_pkg::DV_REF && // [R12]
    refresh_row_r == $past(refresh_row_r) + 16'h0001) else $error("Refresh counter wrong.");
  a_sref_entry: assert property (sref_ok |=> dev_r == dcb_pkg::DV_SREF ##1 // [R13]
    (dev_r == dcb_pkg::DV_SREF) || $past(cke)) else $error("Self refresh not held.");
  a_dpd_entry: assert property (dpd_ok |=> dev_r == dcb_pkg::DV_DPD && data_lost_r) // [R15]
    else $error("Deep power-down not entered.");
  a_rd_accept: assert property (rd_ok |=> burst_live_r && burst_rd_r && // [R17]
    burst_bank_r == $past(ba)) else $error("Read not started.");
  a_pre_cuts: assert property (pre_ok && !a10 && burst_live_r && ba == burst_bank_r // [R18]
    |=> !burst_live_r) else $error("Precharge did not cut the burst.");
  a_rcd_expiry: assert property (bank_st_r[2] == dcb_pkg::BK_ACTING && bank_cnt_r[2] == 8'h01 // [R22]
    && !act_ok |=> bank_st_r[2] == dcb_pkg::BK_ACTIVE) else $error("Activate delay overran.");

  c_read_burst: cover property (rd_ok ##1 burst_live_r [*2] ##1 rdata_valid);
  c_write_masked: cover property (burst_live_r && !burst_rd_r && write_byte_mask == 2'h1);
  c_burst_term: cover property (bst_ok);
  c_self_refresh: cover property (sref_ok ##[1:20] dev_r == dcb_pkg::DV_NORM);
endmodule // dcb_top
`default_nettype wire

// ==== verif/dcb_ctl_model.sv ====
/*
 * Controller-side model: drives commands, addresses and write beats, and collects read beats.
 * Assumes the bench calls its tasks in a legal order and the burst length is at its reset value.
 */
`timescale 1ns/1ns
`default_nettype none
module dcb_ctl_model (
  input  wire logic        aclk,
  output var  logic        cke,
  output var  logic        cs_n,
  output var  logic        ras_n,
  output var  logic        cas_n,
  output var  logic        we_n,
  output var  logic        bank_sel_bit0,
  output var  logic        bank_sel_bit1,
  output var  logic [12:0] addr,
  output var  logic [15:0] wdata,
  output var  logic [1:0]  write_byte_mask,
  input  wire logic [15:0] rdata,
  input  wire logic        rdata_valid
);
  // ****************************************
  // Command driver and read capture
  // ****************************************
  logic [15:0] rq[$];
  // Pins idle from time zero; clock enable starts high, then holds the level given with each command.
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
    {bank_sel_bit1, bank_sel_bit0, addr} = 15'h0;
    {wdata, write_byte_mask} = 18'h3;
  end
  // One command for one edge, then no-operation with the bank and address lines driven inverted.
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic k);
    @(posedge aclk);
    {cs_n, ras_n, cas_n, we_n} <= c;
    {bank_sel_bit1, bank_sel_bit0, addr} <= {b, a};
    cke <= k;
    @(posedge aclk);
    {cs_n, ras_n, cas_n, we_n} <= 4'h7;
    {bank_sel_bit1, bank_sel_bit0, addr} <= ~{b, a};
  endtask
  // Write command, then one beat and mask per edge until the whole burst is sent.
  task automatic wr4(input logic [1:0] b, input logic [12:0] a, input logic [63:0] d, input logic [7:0] m);
    cmd(4'h4, b, a, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wdata <= d[16*i +: 16];
      write_byte_mask <= m[2*i +: 2];
      @(posedge aclk);
    end
    {wdata, write_byte_mask} <= ~{wdata, write_byte_mask};
  endtask
  // Read beats are taken in mid-cycle, where they are settled.
  always @(negedge aclk) begin
    if (rdata_valid === 1'b1) begin
      rq.push_back(rdata);
    end
  end
endmodule // dcb_ctl_model
`default_nettype wire

// ==== verif/tb_dcb_top.sv ====
/*
 * Bench: AXI4-Lite register tasks and memory command scenarios with expected values.
 * Assumes reset timing values and the controller model standing beside the design.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_dcb_top;
  localparam logic [31:0] IDLE = 32'h01041041;
  localparam logic [31:0] SMSK = 32'h3FFFFFFF;
  localparam logic [63:0] EXPD = 64'h4444_33CC_BB22_AAAA;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cke, cs_n;
  logic        ras_n, cas_n, we_n, bank_sel_bit0, bank_sel_bit1, rdata_valid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, write_byte_mask, r;
  logic [3:0]  s_axi_wstrb;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [12:0] addr;
  logic [15:0] wdata, rdata;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  int          errors, n_checks;
  // ****************************************
  // Clock, design and controller model
  // ****************************************
  initial aclk = 1'b0;
  always #2 aclk = ~aclk;
  dcb_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_sel_bit0, .bank_sel_bit1, .addr,
    .wdata, .write_byte_mask, .rdata, .rdata_valid);
  dcb_ctl_model i_ctl (.aclk, .cke, .cs_n, .ras_n, .cas_n, .we_n, .bank_sel_bit0, .bank_sel_bit1,
    .addr, .wdata, .write_byte_mask, .rdata, .rdata_valid);
  // Compare, report and close the run.
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tmo();
    errors++;
    final_report();
  endtask
  // AXI4-Lite write: address and data offered together, each dropped once taken.
  task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_hit, w_hit, b_hit;
    b_hit = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata} <= {a, v};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (int n = 0; n < 50 && !b_hit; n++) begin
      @(negedge aclk);
      aw_hit = s_axi_awvalid && s_axi_awready === 1'b1;
      w_hit = s_axi_wvalid && s_axi_wready === 1'b1;
      b_hit = s_axi_bvalid === 1'b1;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
      if (b_hit) s_axi_bready <= 1'b0;
    end
    if (!b_hit) tmo();
  endtask
  // AXI4-Lite read: rready held until the data are seen.
  task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ar_hit, r_hit;
    r_hit = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (int n = 0; n < 50 && !r_hit; n++) begin
      @(negedge aclk);
      ar_hit = s_axi_arvalid && s_axi_arready === 1'b1;
      r_hit = s_axi_rvalid === 1'b1;
      {v, rs} = {s_axi_rdata, s_axi_rresp};
      @(posedge aclk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
      if (r_hit) s_axi_rready <= 1'b0;
    end
    if (!r_hit) tmo();
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axr(a, d, r);
    chk(nm, d & m, e);
  endtask
  // Main sequence: registers first, then bank commands.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rchk("timing", dcb_pkg::OFF_TIMING, '1, dcb_pkg::TIMING_RST);
    rchk("burst", dcb_pkg::OFF_BURST, 32'h1F, 32'(dcb_pkg::BURST_RST));
    axw(dcb_pkg::OFF_STATUS, '1, r);
    chk("ro write", 32'(r), 32'(dcb_pkg::RESP_OKAY));
    axw(8'h40, '1, r);
    chk("bad write", 32'(r), 32'(dcb_pkg::RESP_SLVERR));
    axr(8'h40, d, r);
    chk("bad read", 32'(r), 32'(dcb_pkg::RESP_SLVERR));
    rchk("status", dcb_pkg::OFF_STATUS, SMSK, IDLE);
    i_ctl.cmd(4'h3, 2'h1, 13'h0001, 1'b1);
    repeat (3) @(posedge aclk);
    rchk("bank open", dcb_pkg::OFF_STATUS, SMSK, 32'h01041101);
    i_ctl.wr4(2'h1, 13'h0002, 64'h4444_3333_2222_1111, 8'h00);
    i_ctl.wr4(2'h1, 13'h0002, 64'hDDDD_CCCC_BBBB_AAAA, 8'hE4);
    i_ctl.rq.delete();
    i_ctl.cmd(4'h5, 2'h1, 13'h0402, 1'b1);
    for (int i = 0; i < 50 && i_ctl.rq.size() < 4; i++) @(posedge aclk);
    if (i_ctl.rq.size() < 4) tmo();
    for (int k = 0; k < 4; k++) chk("beat", 32'(i_ctl.rq[k]), 32'(EXPD[16*k +: 16]));
    i_ctl.cmd(4'hB, 2'h2, 13'h0000, 1'b1);
    repeat (4) @(posedge aclk);
    rchk("deselect", dcb_pkg::OFF_STATUS, SMSK, IDLE);
    i_ctl.cmd(4'h3, 2'h2, 13'h0000, 1'b1);
    repeat (3) @(posedge aclk);
    i_ctl.rq.delete();
    i_ctl.cmd(4'h5, 2'h2, 13'h0000, 1'b1);
    i_ctl.cmd(4'h6, 2'h0, 13'h0000, 1'b1);
    repeat (8) @(posedge aclk);
    chk("cut burst", 32'(i_ctl.rq.size() < 4), 32'h1);
    rchk("row kept", dcb_pkg::OFF_STATUS, SMSK, 32'h01044041);
    i_ctl.cmd(4'h2, 2'h3, 13'h0400, 1'b1);
    repeat (4) @(posedge aclk);
    rchk("all closed", dcb_pkg::OFF_STATUS, SMSK, IDLE);
    i_ctl.cmd(4'h0, 2'h1, 13'h0123, 1'b1);
    rchk("mode", dcb_pkg::OFF_MODE, '1, 32'h2123);
    rchk("refresh base", dcb_pkg::OFF_REFCNT, 32'hFFFF, 32'h0);
    i_ctl.cmd(4'h1, 2'h0, 13'h1FFF, 1'b1);
    repeat (9) @(posedge aclk);
    rchk("refresh row", dcb_pkg::OFF_REFCNT, 32'hFFFF, 32'h1);
    i_ctl.cmd(4'h1, 2'h0, 13'h0000, 1'b0);
    i_ctl.cmd(4'h7, 2'h0, 13'h0000, 1'b1);
    i_ctl.cmd(4'h1, 2'h0, 13'h0000, 1'b1);
    repeat (9) @(posedge aclk);
    rchk("self refresh", dcb_pkg::OFF_REFCNT, 32'hFFFF, 32'h3);
    i_ctl.cmd(4'h6, 2'h0, 13'h0000, 1'b0);
    rchk("power down", dcb_pkg::OFF_STATUS, 32'h3F000000, 32'h30000000);
    final_report();
  end
endmodule // tb_dcb_top
`default_nettype wire
